// File: logic/exception_vector_priority_unit.sv
// Overview of operation
// RQ1 - three vector classes: reset, translation miss, general
// RQ2 - boot vector set when select bit one
// RQ3 - normal vector set when select bit zero
// RQ4 - reset forces boot vector select to one
// RQ5 - four pipeline stages report exception flags
// RQ6 - most advanced stage exception wins
// RQ7 - flush younger stages on exception
// RQ8 - fixed cause ranking from reset downward
// RQ9 - translation exceptions never raised
// RQ10 - decode trap beats younger fetch fault
// RQ11 - vector becomes the very next fetch
// RQ12 - handler reached one cycle after recognition
// RQ13 - flushed instructions refetched after handler
// RQ14 - six interrupt and two branch-condition inputs
// RQ15 - boot vectors uncached, normal vectors cached
// RQ16 - push privilege and enable stack, clear current
// RQ17 - load return pc on exception
// RQ18 - resolve priority each cycle, redirect at once
`timescale 1ns/1ps
module exception_vector_priority_unit
    import exc_pkg::*;
(
    input wire logic clk, // processor clock
    input wire logic rst_n, // async reset, active low
    input wire logic pipe_run, // run cycle, low while stalled
    input wire logic address_error_load, // memory stage load address fault
    input wire logic address_error_store, // memory stage store address fault
    input wire logic load_store_bus_fault, // memory stage bus fault
    input wire logic [31:0] mem_pc, // pc of memory stage instruction
    input wire logic alu_valid, // alu stage holds an instruction
    input wire logic alu_overflow, // alu stage overflow
    input wire logic [31:0] alu_pc, // pc of alu stage instruction
    input wire logic rd_syscall, // decode stage system call
    input wire logic breakpoint_trap, // decode stage breakpoint
    input wire logic undefined_opcode_trap, // decode stage reserved opcode
    input wire logic rd_cop_unusable, // decode stage coprocessor unusable
    input wire logic [31:0] rd_pc, // pc of decode stage instruction
    input wire logic fetch_address_phase_fault, // fetch address error
    input wire logic fetch_bus_fault, // fetch bus error
    input wire logic [31:0] if_pc, // pc of fetch stage instruction
    input wire logic rfe_strobe, // restore from exception, pops stack
    input wire logic [5:0] irq_in_n, // external interrupts, active low
    input wire logic [5:0] pio_irq_en, // pin muxed as interrupt
    input wire logic [1:0] branch_condition_input, // branch condition pins
    input wire logic [1:0] pio_branch_condition_input_en, // pin muxed as branch condition
    input wire logic [4:0] avs_address, // avalon byte address
    input wire logic avs_read, // avalon read
    input wire logic avs_write, // avalon write
    input wire logic [31:0] avs_writedata, // avalon write data
    input wire logic [3:0] avs_byteenable, // avalon byte enables
    output logic [31:0] avs_readdata, // avalon read data
    output logic avs_waitrequest, // avalon wait
    output logic irq, // level interrupt out
    output logic redirect_valid, // one-cycle fetch redirect
    output logic [31:0] redirect_pc, // virtual vector
    output logic [31:0] redirect_phys, // physical vector
    output logic [1:0] redirect_class, // vector class
    output logic vector_uncached, // vector in uncached space
    output logic [3:0] flush, // {if, rd, alu, mem} kill mask
    output logic [3:0] cause, // cause of taken exception
    output logic [31:0] exception_return_pc, // return address
    output logic privilege_current, // current privilege bit
    output logic irq_enable_current, // current interrupt enable
    output logic [1:0] branch_condition_input_value // branch condition for pipeline
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] status_r;
    logic [EVT_W-1:0] evt_r;
    logic [EVT_W-1:0] mask_r;
    logic [1:0] swirq_r;
    logic reset_pending_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic irq_r;
    logic redirect_valid_r;
    logic [31:0] redirect_pc_r;
    logic [31:0] redirect_phys_r;
    vec_class_e redirect_class_r;
    logic uncached_r;
    logic [3:0] flush_r;
    cause_e cause_r;
    logic [31:0] epc_r;
    logic [1:0] branch_condition_input_r;

    logic st_bev;
    logic [7:0] irq_pend;
    logic alu_irq;
    logic [NUM_CAUSES-1:0] flags;
    logic any_flag;
    logic [3:0] win_idx;
    logic take;
    logic bus_access;
    logic bus_hit;
    logic [31:0] wmask;
    logic [EVT_W-1:0] evt_set;
    logic [31:0] rdata_nxt;

    assign st_bev = status_r[ST_BEV];

    // ------------------------------------------------------------
    // interrupt sampling
    // ------------------------------------------------------------
    // RQ14 muxed interrupt inputs
    assign irq_pend = {(~irq_in_n) & pio_irq_en, swirq_r};
    assign alu_irq = alu_valid & status_r[ST_IEC] & (|(irq_pend & status_r[ST_IM_LO +: 8]));

    // ------------------------------------------------------------
    // priority resolution
    // ------------------------------------------------------------
    // RQ8 flags in ranked order
    // RQ9 no translation flags exist
    assign flags = {fetch_bus_fault, fetch_address_phase_fault,
                    rd_cop_unusable, undefined_opcode_trap, breakpoint_trap, rd_syscall,
                    alu_irq, alu_overflow,
                    load_store_bus_fault, address_error_store, address_error_load};

    // RQ6 oldest stage picked
    // RQ18 resolved every cycle
    first_flag_pick #(
        .N(NUM_CAUSES),
        .W(4)
    ) u_pick (
        .flags(flags),
        .any(any_flag),
        .idx(win_idx)
    );

    // recognised on a run cycle, reset entry on its own
    assign take = reset_pending_r | (pipe_run & any_flag);

    // ------------------------------------------------------------
    // reset entry
    // ------------------------------------------------------------
    // RQ1 reset class raised once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_pending_r <= 1'b1;
        end else begin
            reset_pending_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // fetch redirect and vector select
    // ------------------------------------------------------------
    // RQ11 vector is next fetch
    // RQ12 one cycle to handler
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            redirect_valid_r <= 1'b0;
            redirect_pc_r <= VEC_RESET_VIRT;
            redirect_phys_r <= VEC_RESET_PHYS;
            redirect_class_r <= VC_RESET;
            uncached_r <= 1'b1;
        end else begin
            redirect_valid_r <= take;
            if (take) begin
                // RQ15 cacheability follows select
                uncached_r <= st_bev | reset_pending_r;
                if (reset_pending_r) begin
                    // RQ1 reset vector fixed
                    redirect_class_r <= VC_RESET;
                    redirect_pc_r <= VEC_RESET_VIRT;
                    redirect_phys_r <= VEC_RESET_PHYS;
                end else if (st_bev) begin
                    // RQ2 boot vector set
                    redirect_class_r <= VC_GENERAL;
                    redirect_pc_r <= VEC_GEN_BOOT_VIRT;
                    redirect_phys_r <= VEC_GEN_BOOT_PHYS;
                end else begin
                    // RQ3 normal vector set
                    redirect_class_r <= VC_GENERAL;
                    redirect_pc_r <= VEC_GEN_NORM_VIRT;
                    redirect_phys_r <= VEC_GEN_NORM_PHYS;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // flush, cause and return pc
    // ------------------------------------------------------------
    // RQ7 kill younger stages
    // RQ13 return pc allows refetch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flush_r <= FLUSH_NONE;
            cause_r <= CA_NONE;
            epc_r <= 32'h0000_0000;
        end else begin
            flush_r <= FLUSH_NONE;
            if (reset_pending_r) begin
                flush_r <= FLUSH_MEM;
                cause_r <= CA_RESET;
            end else if (take) begin
                // RQ5 stage of winner sets flush
                cause_r <= cause_e'(win_idx + CAUSE_IDX_OFS);
                // RQ17 return pc of faulting instruction
                if (win_idx <= LAST_MEM_IDX) begin
                    flush_r <= FLUSH_MEM;
                    epc_r <= mem_pc;
                end else if (win_idx <= LAST_ALU_IDX) begin
                    flush_r <= FLUSH_ALU;
                    epc_r <= alu_pc;
                end else if (win_idx <= LAST_RD_IDX) begin
                    // RQ10 decode before fetch
                    flush_r <= FLUSH_RD;
                    epc_r <= rd_pc;
                end else begin
                    flush_r <= FLUSH_IF;
                    epc_r <= if_pc;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // avalon slave
    // ------------------------------------------------------------
    assign bus_access = (avs_read | avs_write) & ~wait_r;
    assign bus_hit = (avs_address == REG_STATUS) | (avs_address == REG_EVT) |
                     (avs_address == REG_MASK) | (avs_address == REG_EPC) |
                     (avs_address == REG_PINS) | (avs_address == REG_SWIRQ);
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // one wait cycle, then a single ready cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~((avs_read | avs_write) & wait_r);
        end
    end

    // read mux, unmapped reads zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (avs_address)
            REG_STATUS: rdata_nxt = status_r;
            REG_EVT: rdata_nxt = {29'h0, evt_r};
            REG_MASK: rdata_nxt = {29'h0, mask_r};
            REG_EPC: rdata_nxt = epc_r;
            REG_PINS: rdata_nxt = {22'h0, branch_condition_input_r, irq_pend};
            REG_SWIRQ: rdata_nxt = {30'h0, swirq_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
        if (!bus_hit) begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    // read data captured as wait falls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read & wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // status word: stack, select bit, mask
    // ------------------------------------------------------------
    // RQ4 select forced to one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= STATUS_RST;
        end else if (take & ~reset_pending_r) begin
            // RQ16 push stack, kernel, masked
            status_r[ST_STACK_HI:0] <= {status_r[ST_STACK_HI-2:0], 2'b00};
        end else if (rfe_strobe) begin
            status_r[ST_STACK_HI:0] <= {status_r[ST_STACK_HI:ST_STACK_HI-1],
                                        status_r[ST_STACK_HI:2]};
        end else if (bus_access & avs_write & (avs_address == REG_STATUS)) begin
            status_r <= (status_r & ~(wmask & STATUS_WMASK)) |
                        (avs_writedata & wmask & STATUS_WMASK);
        end
    end

    // software interrupts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swirq_r <= 2'b00;
        end else if (bus_access & avs_write & (avs_address == REG_SWIRQ) & avs_byteenable[0]) begin
            swirq_r <= avs_writedata[1:0];
        end
    end

    // ------------------------------------------------------------
    // event status, mask and interrupt out
    // ------------------------------------------------------------
    assign evt_set = {take & ~reset_pending_r & (win_idx == 4'h2 || win_idx == 4'ha),
                      take & ~reset_pending_r & (win_idx == 4'h4),
                      take & ~reset_pending_r};

    // sticky bits, set beats write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_r <= '0;
        end else if (bus_access & avs_write & (avs_address == REG_EVT) & avs_byteenable[0]) begin
            evt_r <= (evt_r & ~avs_writedata[EVT_W-1:0]) | evt_set;
        end else begin
            evt_r <= evt_r | evt_set;
        end
    end

    // event mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= '0;
        end else if (bus_access & avs_write & (avs_address == REG_MASK) & avs_byteenable[0]) begin
            mask_r <= avs_writedata[EVT_W-1:0];
        end
    end

    // interrupt level and branch conditions
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
            branch_condition_input_r <= 2'b00;
        end else begin
            irq_r <= |(evt_r & mask_r);
            // RQ14 muxed branch conditions
            branch_condition_input_r <= branch_condition_input & pio_branch_condition_input_en;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign irq = irq_r;
    assign redirect_valid = redirect_valid_r;
    assign redirect_pc = redirect_pc_r;
    assign redirect_phys = redirect_phys_r;
    assign redirect_class = redirect_class_r;
    assign vector_uncached = uncached_r;
    assign flush = flush_r;
    assign cause = cause_r;
    assign exception_return_pc = epc_r;
    assign privilege_current = status_r[ST_KUC];
    assign irq_enable_current = status_r[ST_IEC];
    assign branch_condition_input_value = branch_condition_input_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_reset_vec;
        @(posedge clk) disable iff (!rst_n)
        (rst_n && reset_pending_r) |=>
            redirect_valid_r && redirect_pc_r == VEC_RESET_VIRT && st_bev;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector missed"); // RQ4

    property p_boot_vec;
        @(posedge clk) disable iff (!rst_n)
        (take && !reset_pending_r && st_bev) |=>
            redirect_pc_r == VEC_GEN_BOOT_VIRT && redirect_phys_r == VEC_GEN_BOOT_PHYS;
    endproperty
    a_boot_vec: assert property (p_boot_vec) else $error("boot vector wrong"); // RQ2

    property p_norm_vec;
        @(posedge clk) disable iff (!rst_n)
        (take && !reset_pending_r && !st_bev) |=>
            redirect_pc_r == VEC_GEN_NORM_VIRT && redirect_phys_r == VEC_GEN_NORM_PHYS;
    endproperty
    a_norm_vec: assert property (p_norm_vec) else $error("normal vector wrong"); // RQ3

    property p_mem_first;
        @(posedge clk) disable iff (!rst_n)
        (pipe_run && !reset_pending_r && address_error_load) |=> cause_r == CA_ADDR_LOAD;
    endproperty
    a_mem_first: assert property (p_mem_first) else $error("load fault not first"); // RQ6

    property p_rd_before_if;
        @(posedge clk) disable iff (!rst_n)
        (pipe_run && !reset_pending_r && flags[6:0] == 7'h00 && undefined_opcode_trap &&
         fetch_bus_fault) |=> cause_r == CA_UNDEF && flush_r == FLUSH_RD;
    endproperty
    a_rd_before_if: assert property (p_rd_before_if) else $error("decode trap lost"); // RQ10

    property p_alu_flush;
        @(posedge clk) disable iff (!rst_n)
        (take && !reset_pending_r && flags[2:0] == 3'h0 && alu_overflow) |=>
            flush_r == FLUSH_ALU && epc_r == $past(alu_pc);
    endproperty
    a_alu_flush: assert property (p_alu_flush) else $error("alu flush or pc wrong"); // RQ7

    property p_one_cycle;
        @(posedge clk) disable iff (!rst_n)
        (rst_n && take && !$past(take)) |=> redirect_valid_r;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("redirect late"); // RQ12

    property p_stack;
        @(posedge clk) disable iff (!rst_n)
        (take && !reset_pending_r) |=> status_r[1:0] == 2'b00 &&
            status_r[3:2] == $past(status_r[1:0]) && status_r[5:4] == $past(status_r[3:2]);
    endproperty
    a_stack: assert property (p_stack) else $error("status stack wrong"); // RQ16

    property p_cache;
        @(posedge clk) disable iff (!rst_n)
        (take && !reset_pending_r) |=> uncached_r == $past(st_bev);
    endproperty
    a_cache: assert property (p_cache) else $error("cacheability wrong"); // RQ15

    property p_no_tlb;
        @(posedge clk) disable iff (!rst_n)
        redirect_valid_r |-> redirect_class_r != VC_UTLB;
    endproperty
    a_no_tlb: assert property (p_no_tlb) else $error("translation class raised"); // RQ9

endmodule : exception_vector_priority_unit

// File: logic/exc_pkg.sv
package exc_pkg;

    // ------------------------------------------------------------
    // exception vectors, virtual and physical
    // ------------------------------------------------------------
    localparam logic [31:0] VEC_RESET_VIRT = 32'hbfc0_0000;
    localparam logic [31:0] VEC_RESET_PHYS = 32'h1fc0_0000;
    localparam logic [31:0] VEC_UTLB_BOOT_VIRT = 32'hbfc0_0100;
    localparam logic [31:0] VEC_UTLB_BOOT_PHYS = 32'h1fc0_0100;
    localparam logic [31:0] VEC_GEN_BOOT_VIRT = 32'hbfc0_0180;
    localparam logic [31:0] VEC_GEN_BOOT_PHYS = 32'h1fc0_0180;
    localparam logic [31:0] VEC_UTLB_NORM_VIRT = 32'h8000_0000;
    localparam logic [31:0] VEC_UTLB_NORM_PHYS = 32'h0000_0000;
    localparam logic [31:0] VEC_GEN_NORM_VIRT = 32'h8000_0080;
    localparam logic [31:0] VEC_GEN_NORM_PHYS = 32'h0000_0080;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] REG_STATUS = 5'h00;
    localparam logic [4:0] REG_EVT = 5'h04;
    localparam logic [4:0] REG_MASK = 5'h08;
    localparam logic [4:0] REG_EPC = 5'h0c;
    localparam logic [4:0] REG_PINS = 5'h10;
    localparam logic [4:0] REG_SWIRQ = 5'h14;

    // ------------------------------------------------------------
    // status word fields and reset values
    // ------------------------------------------------------------
    localparam int ST_IEC = 0;
    localparam int ST_KUC = 1;
    localparam int ST_STACK_HI = 5;
    localparam int ST_IM_LO = 8;
    localparam int ST_BEV = 22;
    localparam logic [31:0] STATUS_WMASK = 32'h0040_ff3f;
    localparam logic [31:0] STATUS_RST = 32'h0040_0000;

    // event bits of the sticky status and mask registers
    localparam int EVT_EXC = 0;
    localparam int EVT_IRQ = 1;
    localparam int EVT_FAULT = 2;
    localparam int EVT_W = 3;

    // flush masks {fetch, decode, alu, memory}
    localparam logic [3:0] FLUSH_NONE = 4'h0;
    localparam logic [3:0] FLUSH_MEM = 4'hf;
    localparam logic [3:0] FLUSH_ALU = 4'he;
    localparam logic [3:0] FLUSH_RD = 4'hc;
    localparam logic [3:0] FLUSH_IF = 4'h8;

    // priority-ordered flags, index 0 highest
    localparam int NUM_CAUSES = 11;
    localparam logic [3:0] LAST_MEM_IDX = 4'h2;
    localparam logic [3:0] LAST_ALU_IDX = 4'h4;
    localparam logic [3:0] LAST_RD_IDX = 4'h8;
    localparam logic [3:0] CAUSE_IDX_OFS = 4'h2;

    typedef enum logic [1:0] {
        VC_RESET = 2'b00,
        VC_UTLB = 2'b01,
        VC_GENERAL = 2'b10
    } vec_class_e;

    typedef enum logic [3:0] {
        CA_NONE = 4'h0,
        CA_RESET = 4'h1,
        CA_ADDR_LOAD = 4'h2,
        CA_ADDR_STORE = 4'h3,
        CA_LS_BUS = 4'h4,
        CA_OVF = 4'h5,
        CA_IRQ = 4'h6,
        CA_SYSCALL = 4'h7,
        CA_BREAK = 4'h8,
        CA_UNDEF = 4'h9,
        CA_COP_UNUSABLE = 4'ha,
        CA_FETCH_ADDR = 4'hb,
        CA_FETCH_BUS = 4'hc
    } cause_e;

endpackage : exc_pkg

// File: logic/first_flag_pick.sv
`timescale 1ns/1ps
module first_flag_pick #(
    parameter int N = 11,
    parameter int W = 4
) (
    input wire logic [N-1:0] flags, // priority-ordered flags
    output logic any, // some flag set
    output logic [W-1:0] idx // lowest set index
);

    // lowest index wins, scanned from the top down
    always_comb begin
        any = |flags;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (flags[i]) begin
                idx = W'(i);
            end
        end
    end

endmodule : first_flag_pick

// File: dv/pipe_model.sv
`timescale 1ns/1ps
module pipe_model (
    input wire logic clk, // processor clock
    input wire logic rst_n, // async reset, active low
    input wire logic ld, // load new stage flags
    input wire logic [9:0] req, // {mem 3, alu 1, rd 4, if 2}
    input wire logic [3:0] flush, // {if, rd, alu, mem} kill mask
    output logic [9:0] flg // flags shown to the unit
);
    logic [9:0] flg_r;
    // a killed stage shows no flag
    assign flg = flg_r & ~{{3{flush[0]}}, flush[1], {4{flush[2]}}, {2{flush[3]}}};
    // flags persist until the stage is killed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flg_r <= 10'h000;
        end else begin
            flg_r <= ld ? req : flg;
        end
    end
endmodule : pipe_model

// File: dv/exception_vector_priority_unit_tb_top.sv
`timescale 1ns/1ps
module exception_vector_priority_unit_tb_top;
    import exc_pkg::*;
    typedef struct packed {
        logic [9:0] f;
        logic ip;
        logic boot_vector_select;
        cause_e c;
        logic [3:0] fl;
    } row_s;
    // flags, irq pin, select, cause, flush
    row_s rows [11] = '{'{10'h380, '0, '1, CA_ADDR_LOAD, 4'hf},
        '{10'h100, '0, '1, CA_ADDR_STORE, 4'hf}, '{10'h0ff, '0, '0, CA_LS_BUS, 4'hf},
        '{10'h07f, '0, '1, CA_OVF, 4'he}, '{10'h03c, '1, '0, CA_IRQ, 4'he},
        '{10'h03c, '0, '1, CA_SYSCALL, 4'hc}, '{10'h01f, '0, '0, CA_BREAK, 4'hc},
        '{10'h00b, '0, '1, CA_UNDEF, 4'hc}, '{10'h004, '0, '0, CA_COP_UNUSABLE, 4'hc},
        '{10'h003, '0, '1, CA_FETCH_ADDR, 4'h8}, '{10'h001, '0, '0, CA_FETCH_BUS, 4'h8}};
    logic clk, rst_n, pipe_run, ld, rfe_strobe, avs_read, avs_write;
    logic [9:0] req, mf;
    logic [31:0] pc_b, avs_writedata, q, avs_readdata, redirect_pc, redirect_phys;
    logic [31:0] exception_return_pc, e;
    logic [5:0] irq_in_n;
    logic [4:0] avs_address;
    logic avs_waitrequest, irq, redirect_valid, vector_uncached;
    logic privilege_current, irq_enable_current;
    logic [3:0] flush, cause;
    logic [1:0] redirect_class, branch_condition_input_value;
    row_s r;
    int n_errors = 0;
    int n_checks = 0;
    pipe_model i_pipe_model (.clk, .rst_n, .ld, .req, .flush, .flg(mf));
    exception_vector_priority_unit i_exception_vector_priority_unit (.clk, .rst_n,
        .pipe_run, .address_error_load(mf[9]), .address_error_store(mf[8]),
        .load_store_bus_fault(mf[7]), .mem_pc(pc_b + 32'h10), .alu_valid(1'b1),
        .alu_overflow(mf[6]), .alu_pc(pc_b + 32'h20), .rd_syscall(mf[5]),
        .breakpoint_trap(mf[4]), .undefined_opcode_trap(mf[3]), .rd_cop_unusable(mf[2]),
        .rd_pc(pc_b + 32'h30), .fetch_address_phase_fault(mf[1]), .fetch_bus_fault(mf[0]),
        .if_pc(pc_b + 32'h40), .rfe_strobe, .irq_in_n, .pio_irq_en(6'h3f),
        .branch_condition_input(2'h3), .pio_branch_condition_input_en(2'h2), .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
        .irq, .redirect_valid, .redirect_pc, .redirect_phys, .redirect_class,
        .vector_uncached, .flush, .cause, .exception_return_pc, .privilege_current,
        .irq_enable_current, .branch_condition_input_value);
    always #5 clk = ~clk;
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        n_checks++;
        if (s !== x) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    // avalon cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        chk("waitrequest", 0, avs_waitrequest);
        if (avs_waitrequest !== 1'b0) conclude();
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wait_rv(input logic [31:0] v, input logic [31:0] p);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (redirect_valid !== 1'b1 && k < 20);
        chk("redirect", 1, redirect_valid);
        if (redirect_valid !== 1'b1) conclude();
        chk("pc", v, redirect_pc);
        chk("phys", p, redirect_phys);
    endtask : wait_rv
    initial begin
        clk = 0;
        rst_n = 0;
        {pipe_run, ld, rfe_strobe, avs_read, avs_write} = 5'h10;
        {req, pc_b, avs_writedata, avs_address} = '0;
        irq_in_n = 6'h3f;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wait_rv(VEC_RESET_VIRT, VEC_RESET_PHYS);
        chk("rst_cause", CA_RESET, cause);
        chk("rst_flush", 4'hf, flush);
        chk("rst_unc", 1, vector_uncached);
        bus(0, REG_STATUS, 0);
        chk("rst_status", STATUS_RST, q);
        foreach (rows[i]) begin
            r = rows[i];
            bus(1, REG_STATUS, {9'h0, r.boot_vector_select, 11'h0, r.ip, 10'h003});
            pc_b <= i << 8;
            pipe_run <= 1'b0;
            req <= r.f;
            ld <= 1'b1;
            irq_in_n <= {5'h1f, !r.ip};
            @(posedge clk);
            ld <= 1'b0;
            repeat (3) @(posedge clk);
            chk("stall", 0, redirect_valid);
            pipe_run <= 1'b1;
            wait_rv(r.boot_vector_select ? VEC_GEN_BOOT_VIRT : VEC_GEN_NORM_VIRT,
                r.boot_vector_select ? VEC_GEN_BOOT_PHYS : VEC_GEN_NORM_PHYS);
            e = pc_b + (r.fl == 4'hf ? 32'h10 : r.fl == 4'he ? 32'h20 :
                r.fl == 4'hc ? 32'h30 : 32'h40);
            chk("cause", r.c, cause);
            chk("flush", r.fl, flush);
            chk("class", VC_GENERAL, redirect_class);
            chk("unc", r.boot_vector_select, vector_uncached);
            chk("epc", e, exception_return_pc);
            chk("kuie", 0, {privilege_current, irq_enable_current});
            chk("irq_masked", 0, irq);
            irq_in_n <= 6'h3f;
            bus(0, REG_STATUS, 0);
            chk("status", {9'h0, r.boot_vector_select, 11'h0, r.ip, 10'h00c}, q);
        end
        // stack pop on return
        rfe_strobe <= 1'b1;
        @(posedge clk);
        rfe_strobe <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pop", 3, {privilege_current, irq_enable_current});
        // sticky event, mask and clear
        bus(0, REG_EVT, 0);
        chk("evt", 1, q[0]);
        bus(1, REG_MASK, 1);
        repeat (3) @(posedge clk);
        chk("irq_on", 1, irq);
        bus(1, REG_EVT, 32'h7);
        repeat (3) @(posedge clk);
        chk("irq_off", 0, irq);
        bus(0, 5'h1c, 0);
        chk("unmapped", 0, q);
        chk("branch_condition_input", 2, branch_condition_input_value);
        // software interrupt taken as an interrupt exception
        bus(1, REG_SWIRQ, 1);
        bus(1, REG_STATUS, 32'h0000_0101);
        wait_rv(VEC_GEN_NORM_VIRT, VEC_GEN_NORM_PHYS);
        chk("sw_cause", CA_IRQ, cause);
        bus(0, REG_PINS, 0);
        chk("pins", 32'h0000_0201, q);
        // mid-run reset forces the boot select back
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        wait_rv(VEC_RESET_VIRT, VEC_RESET_PHYS);
        bus(0, REG_STATUS, 0);
        chk("rst2_status", STATUS_RST, q);
        conclude();
    end
endmodule : exception_vector_priority_unit_tb_top
